// ===== rtl/lcc_charger.sv
// charge controller state machine with timers, flags and register slave
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module lcc_charger #(
    parameter longint unsigned TICK_CYCLES = lcc_pkg::TICK_CYCLES,
    parameter int unsigned     PREQUAL_LIM = lcc_pkg::PREQUAL_MIN,
    parameter int unsigned     CHARGE_LIM  = lcc_pkg::CHARGE_MIN,
    parameter int unsigned     TOPOFF_LIM  = lcc_pkg::TOPOFF_MIN
) (
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    input  wire logic               enable_n,
    input  wire lcc_pkg::lcc_sense_t sense,
    output logic                    power_good_n_oe,
    output logic                    charging_n_oe,
    output logic                    fault_n_oe,
    output logic [1:0]              setpoint,
    output logic                    irq,
    // axi4-lite slave
    input  wire logic [5:0]         s_awaddr,
    input  wire logic               s_awvalid,
    output logic                    s_awready,
    input  wire logic [31:0]        s_wdata,
    input  wire logic [3:0]         s_wstrb,
    input  wire logic               s_wvalid,
    output logic                    s_wready,
    output logic [1:0]              s_bresp,
    output logic                    s_bvalid,
    input  wire logic               s_bready,
    input  wire logic [5:0]         s_araddr,
    input  wire logic               s_arvalid,
    output logic                    s_arready,
    output logic [31:0]             s_rdata,
    output logic [1:0]              s_rresp,
    output logic                    s_rvalid,
    input  wire logic               s_rready
);

    localparam int unsigned TW = 24;   // timer width, wide enough for scaled limits
    // three-stage synchronisers for the pins, 9 bits
    logic [8:0] sy1_q;
    logic [8:0] sy2_q;
    logic [8:0] sy3_q;
    logic [8:0] pin_q;

    // pins cross from the analog domain; accept when stages 2 and 3 agree
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sy1_q <= 9'h001;
            sy2_q <= 9'h001;
            sy3_q <= 9'h001;
            pin_q <= 9'h001;
        end else begin
            sy1_q <= {sense, enable_n};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            for (int i = 0; i < 9; i++) begin
                if (sy2_q[i] == sy3_q[i]) begin
                    pin_q[i] <= sy3_q[i];
                end
            end
        end
    end

    lcc_pkg::lcc_sense_t sn;
    logic                en_n;
    assign en_n = pin_q[0];
    assign sn   = lcc_pkg::lcc_sense_t'(pin_q[8:1]);

    // supply usable only when valid and not over the lockout
    logic supply_ok;
    assign supply_ok = sn.supply_valid && !sn.supply_over;
    // thermistor decode: temperature allows charging
    logic temp_ok;
    assign temp_ok = sn.thm_below_315 || (!sn.thm_below_3k94 && !sn.thm_above_28k3);
    // timebase divider standing in for the capacitor oscillator
    logic [31:0] div_q;
    logic        tick;
    assign tick = (div_q == 32'(TICK_CYCLES - 64'd1));

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_q <= 32'h0;
        end else if (tick) begin
            div_q <= 32'h0;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end

    // software timer scale in eighths of the reference capacitor
    logic [7:0] scale_q;
    function automatic logic [TW-1:0] scaled(input int unsigned lim, input logic [7:0] sc);
        logic [39:0] p;
        p = 40'(lim) * 40'(sc);
        return TW'(p >> lcc_pkg::SCALE_SHIFT);
    endfunction : scaled
    lcc_pkg::lcc_state_t st_q;
    lcc_pkg::lcc_state_t st_d;
    lcc_pkg::lcc_state_t resume_q;  // state to return to after suspend
    logic [TW-1:0]       tmr_q;
    logic [TW-1:0]       limit;
    logic                expired;
    logic                en_prev_q;
    logic                sup_prev_q;
    logic                clear_fault;

    // limits scale with the capacitor setting
    always_comb begin
        unique case (st_q)
            lcc_pkg::ST_PREQUAL: limit = scaled(PREQUAL_LIM, scale_q);
            lcc_pkg::ST_CHARGE:  limit = scaled(CHARGE_LIM, scale_q);
            lcc_pkg::ST_TOPOFF:  limit = scaled(TOPOFF_LIM, scale_q);
            default:             limit = {TW{1'b1}};
        endcase
    end
    assign expired = (tmr_q >= limit);

    // enable toggle or supply loss clears the latched fault
    // fault release
    assign clear_fault = (en_n && !en_prev_q) || (!supply_ok && sup_prev_q);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_prev_q  <= 1'b1;
            sup_prev_q <= 1'b0;
        end else begin
            en_prev_q  <= en_n;
            sup_prev_q <= supply_ok;
        end
    end

    // next-state logic
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            lcc_pkg::ST_DISABLE: begin
                if (supply_ok && !en_n) begin
                    st_d = lcc_pkg::ST_PREQUAL;
                end
            end
            lcc_pkg::ST_PREQUAL: begin
                if (!temp_ok) begin
                    st_d = lcc_pkg::ST_THERMAL;
                end else if (sn.bat_above_3v) begin
                    st_d = lcc_pkg::ST_CHARGE;
                end else if (expired) begin
                    st_d = lcc_pkg::ST_FAULT;
                end
            end
            lcc_pkg::ST_CHARGE: begin
                if (!temp_ok) begin
                    st_d = lcc_pkg::ST_THERMAL;
                end else if (sn.cur_below_topoff) begin
                    st_d = lcc_pkg::ST_TOPOFF;
                end else if (expired) begin
                    st_d = lcc_pkg::ST_FAULT;
                end
            end
            lcc_pkg::ST_TOPOFF: begin
                if (expired) begin
                    st_d = lcc_pkg::ST_DONE;
                end
            end
            lcc_pkg::ST_DONE: begin
                if (sn.bat_below_rech) begin
                    st_d = lcc_pkg::ST_CHARGE;
                end
            end
            lcc_pkg::ST_FAULT: begin
                if (clear_fault) begin
                    st_d = lcc_pkg::ST_DISABLE;
                end
            end
            lcc_pkg::ST_THERMAL: begin
                if (temp_ok) begin
                    st_d = resume_q;
                end
            end
            default: st_d = lcc_pkg::ST_DISABLE;
        endcase
        if ((en_n || !supply_ok) && st_q != lcc_pkg::ST_FAULT) begin
            st_d = lcc_pkg::ST_DISABLE;
        end
    end

    // state register and suspend memory
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q     <= lcc_pkg::ST_DISABLE;
            resume_q <= lcc_pkg::ST_PREQUAL;
        end else begin
            st_q <= st_d;
            if (st_d == lcc_pkg::ST_THERMAL && st_q != lcc_pkg::ST_THERMAL) begin
                resume_q <= st_q;
            end
        end
    end

    // timer: restart on entry, freeze in suspend, count ticks otherwise
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tmr_q <= '0;
        end else if (st_d == lcc_pkg::ST_THERMAL || st_q == lcc_pkg::ST_THERMAL) begin
            tmr_q <= tmr_q;
        end else if (st_d != st_q) begin
            tmr_q <= '0;
        end else if (tick && !expired) begin
            tmr_q <= tmr_q + TW'(1);
        end
    end

    // open-drain enables: high pulls the flag low
    logic chg_low_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            power_good_n_oe <= 1'b0;
            chg_low_q       <= 1'b0;
            fault_n_oe      <= 1'b0;
            setpoint        <= lcc_pkg::SET_OFF;
        end else begin
            power_good_n_oe <= supply_ok;
            if (st_d == lcc_pkg::ST_CHARGE) begin
                chg_low_q <= 1'b1;
            end else if (st_d != lcc_pkg::ST_THERMAL) begin
                chg_low_q <= 1'b0;
            end
            if (st_d == lcc_pkg::ST_FAULT) begin
                fault_n_oe <= 1'b1;
            end else if (clear_fault) begin
                fault_n_oe <= 1'b0;
            end
            unique case (st_d)
                lcc_pkg::ST_PREQUAL: setpoint <= lcc_pkg::SET_TENTH;
                lcc_pkg::ST_CHARGE:  setpoint <= lcc_pkg::SET_FULL;
                lcc_pkg::ST_TOPOFF:  setpoint <= lcc_pkg::SET_TOPOFF;
                default:             setpoint <= lcc_pkg::SET_OFF;
            endcase
        end
    end
    assign charging_n_oe = chg_low_q;

    // events: state change, fault, thermal suspend, done
    logic [lcc_pkg::EV_W-1:0] ev;
    logic [lcc_pkg::EV_W-1:0] irq_st_q;
    logic [lcc_pkg::EV_W-1:0] irq_msk_q;
    logic [lcc_pkg::EV_W-1:0] w1c;
    always_comb begin
        ev = '0;
        ev[lcc_pkg::EV_STATE] = (st_d != st_q);
        ev[lcc_pkg::EV_FAULT] = (st_d == lcc_pkg::ST_FAULT) && (st_q != lcc_pkg::ST_FAULT);
        ev[lcc_pkg::EV_THERM] = (st_d == lcc_pkg::ST_THERMAL) && (st_q != lcc_pkg::ST_THERMAL);
        ev[lcc_pkg::EV_DONE]  = (st_d == lcc_pkg::ST_DONE) && (st_q != lcc_pkg::ST_DONE);
    end

    // axi write path: take address and data in either order
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [5:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        do_write;
    assign s_awready = !aw_hold_q && !s_bvalid;
    assign s_wready  = !w_hold_q && !s_bvalid;
    assign do_write  = aw_hold_q && w_hold_q && !s_bvalid;
    assign w1c = (do_write && awaddr_q == lcc_pkg::REG_IRQ_ST && wstrb_q[0])
               ? wdata_q[lcc_pkg::EV_W-1:0] : '0;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 6'h00;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= lcc_pkg::RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= (awaddr_q == lcc_pkg::REG_IRQ_ST || awaddr_q == lcc_pkg::REG_IRQ_MSK
                              || awaddr_q == lcc_pkg::REG_CTRL || awaddr_q == lcc_pkg::REG_STATUS
                              || awaddr_q == lcc_pkg::REG_TIMER)
                             ? lcc_pkg::RESP_OKAY : lcc_pkg::RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // writable registers; status and timer are read only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_msk_q <= '0;
            scale_q   <= lcc_pkg::SCALE_RST;
        end else if (do_write && wstrb_q[0]) begin
            if (awaddr_q == lcc_pkg::REG_IRQ_MSK) begin
                irq_msk_q <= wdata_q[lcc_pkg::EV_W-1:0];
            end
            // zero scale would make every timer expire at once
            if (awaddr_q == lcc_pkg::REG_CTRL && wdata_q[7:0] != 8'h00) begin
                scale_q <= wdata_q[7:0];
            end
        end
    end

    // sticky events: a new event beats a same-cycle clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_st_q <= '0;
            irq      <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~w1c) | ev;
            irq      <= |(((irq_st_q & ~w1c) | ev) & irq_msk_q);
        end
    end

    // read path, answer one cycle after address accepted
    assign s_arready = !s_rvalid;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0;
            s_rresp  <= lcc_pkg::RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp  <= lcc_pkg::RESP_OKAY;
            unique case (s_araddr)
                lcc_pkg::REG_STATUS:  s_rdata <= {21'h0, fault_n_oe, chg_low_q,
                                                  power_good_n_oe, temp_ok, st_q};
                lcc_pkg::REG_IRQ_ST:  s_rdata <= 32'(irq_st_q);
                lcc_pkg::REG_IRQ_MSK: s_rdata <= 32'(irq_msk_q);
                lcc_pkg::REG_CTRL:    s_rdata <= 32'(scale_q);
                lcc_pkg::REG_TIMER:   s_rdata <= 32'(tmr_q);
                default: begin
                    s_rdata <= 32'h0;
                    s_rresp <= lcc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

endmodule : lcc_charger
`default_nettype wire

// ===== rtl/lcc_pkg.sv
// package of the charge controller: states, timing, registers, carriers
package lcc_pkg;

    // charge states, one-hot
    typedef enum logic [6:0] {
        ST_DISABLE = 7'h01,
        ST_PREQUAL = 7'h02,
        ST_CHARGE  = 7'h04,
        ST_TOPOFF  = 7'h08,
        ST_DONE    = 7'h10,
        ST_FAULT   = 7'h20,
        ST_THERMAL = 7'h40
    } lcc_state_t;

    // current setpoint selection
    typedef enum logic [1:0] {
        SET_OFF    = 2'h0,
        SET_TENTH  = 2'h1,
        SET_FULL   = 2'h2,
        SET_TOPOFF = 2'h3
    } lcc_setpoint_t;

    // comparator levels from the analog front end
    typedef struct packed {
        logic supply_valid;   // 4.15 V to 7 V, below lockout
        logic supply_over;    // above 7.5 V lockout
        logic bat_above_3v;   // precharge threshold reached
        logic bat_below_rech; // below 4.05 V recharge threshold
        logic cur_below_topoff; // current under 7.5 % of full
        logic thm_below_315;  // no thermistor fitted
        logic thm_below_3k94; // hot window edge
        logic thm_above_28k3; // cold window edge
    } lcc_sense_t;

    // timing: reference limits in tenths of a minute at 68 nF
    localparam int unsigned PREQUAL_MIN   = 348;   // tenths of a minute, 34.8 min
    localparam int unsigned CHARGE_MIN    = 3340;  // tenths of a minute, 334 min
    localparam int unsigned TOPOFF_MIN    = 348;   // tenths of a minute, 34.8 min
    localparam int unsigned CLK_HZ        = 100_000_000;
    // timebase tick: one tick per tenth of a minute, 6 s
    localparam int unsigned TICK_S_TENTHS = 60;    // tenths of a second per tick
    localparam longint unsigned TICK_CYCLES =
        longint'(CLK_HZ) * longint'(TICK_S_TENTHS) / 64'd10;

    // register map, byte addresses
    localparam logic [5:0] REG_STATUS  = 6'h00;   // live state and flags
    localparam logic [5:0] REG_IRQ_ST  = 6'h04;   // sticky events, write one clears
    localparam logic [5:0] REG_IRQ_MSK = 6'h08;   // interrupt mask
    localparam logic [5:0] REG_CTRL    = 6'h0c;   // timer scale
    localparam logic [5:0] REG_TIMER   = 6'h10;   // running timer value

    // event bit positions
    localparam int unsigned EV_STATE = 0;
    localparam int unsigned EV_FAULT = 1;
    localparam int unsigned EV_THERM = 2;
    localparam int unsigned EV_DONE  = 3;
    localparam int unsigned EV_W     = 4;

    // timer scale reset: 8 eighths = 68 nF reference
    localparam logic [7:0] SCALE_RST = 8'h08;
    localparam int unsigned SCALE_SHIFT = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : lcc_pkg

// ===== tb/lcc_cell_model.sv
// supply, cell and thermistor comparators plus pulled-up status flags
`timescale 1ns/1ps
`default_nettype none
module lcc_cell_model (
    input  var int                  supply_mv,
    input  var int                  bat_mv,
    input  var int                  thm_ohm,
    input  wire logic               taper,
    input  wire logic               power_good_n_oe,
    input  wire logic               charging_n_oe,
    input  wire logic               fault_n_oe,
    output var lcc_pkg::lcc_sense_t sense,
    output logic                    power_good_n,
    output logic                    charging_n,
    output logic                    fault_n
);
    // comparator levels; no hysteresis, the bench never dithers at a threshold
    always_comb begin
        sense.supply_valid = supply_mv >= 4150 && supply_mv <= 7000;
        sense.supply_over = supply_mv > 7500;
        sense.bat_above_3v = bat_mv >= 3000;
        sense.bat_below_rech = bat_mv < 4050;
        sense.cur_below_topoff = taper;
        sense.thm_below_315 = thm_ohm < 315;
        sense.thm_below_3k94 = thm_ohm < 3940;
        sense.thm_above_28k3 = thm_ohm > 28300;
    end
    // open-drain flags with pull-ups at the indicator side
    assign power_good_n = power_good_n_oe ? 1'b0 : 1'b1;
    assign charging_n = charging_n_oe ? 1'b0 : 1'b1;
    assign fault_n = fault_n_oe ? 1'b0 : 1'b1;
endmodule : lcc_cell_model
`default_nettype wire

// ===== tb/lcc_charger_sva.sv
// assertion checker watching the charge controller ports
`timescale 1ns/1ps
`default_nettype none
module lcc_charger_sva (
    input wire logic                clk_sys,
    input wire logic                resetn,
    input wire logic                enable_n,
    input wire lcc_pkg::lcc_sense_t sense,
    input wire logic                power_good_n_oe,
    input wire logic                charging_n_oe,
    input wire logic                fault_n_oe,
    input wire logic [1:0]          setpoint
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    logic [3:0] quiet_q;
    // run of cycles with enable low and supply good; pins lag ~4 cycles, so only a long run counts
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            quiet_q <= 4'h0;
        end else if (enable_n || !sense.supply_valid) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    // stable conditions long enough to cross the pin synchronisers
    sequence s_en_high;
        enable_n [*8];
    endsequence
    sequence s_temp_bad;
        (sense.thm_above_28k3 || (!sense.thm_below_315 && sense.thm_below_3k94)) [*8];
    endsequence

    a_disabled_off: assert property (s_en_high |-> ##2 setpoint == lcc_pkg::SET_OFF)
        else $error("current commanded while enable pin high");
    a_over_inhibit: assert property (sense.supply_over [*8] |-> ##2 setpoint == lcc_pkg::SET_OFF)
        else $error("current commanded with supply over limit");
    a_pgood_on: assert property (sense.supply_valid [*8] |-> ##2 power_good_n_oe)
        else $error("power good not driven with valid supply");
    a_pgood_off: assert property ($fell(sense.supply_valid) |-> ##[1:8] !power_good_n_oe)
        else $error("power good still driven after supply loss");
    a_fault_holds: assert property (fault_n_oe && quiet_q == 4'hf |=> fault_n_oe)
        else $error("fault flag dropped without enable or supply cycle");
    a_fault_clear: assert property (fault_n_oe && $rose(enable_n) |-> ##[1:8] !fault_n_oe)
        else $error("fault flag not cleared by enable toggle");
    a_fault_no_cur: assert property (fault_n_oe |-> setpoint == lcc_pkg::SET_OFF)
        else $error("current commanded while in fault");
    a_fast_flag: assert property (setpoint == lcc_pkg::SET_FULL |-> charging_n_oe)
        else $error("charging flag released in fast charge");
    a_slow_flag: assert property (setpoint inside {lcc_pkg::SET_TENTH, lcc_pkg::SET_TOPOFF} |-> !charging_n_oe)
        else $error("charging flag driven in precharge or top-off");
    a_temp_suspend: assert property (s_temp_bad |-> ##2 !(setpoint inside {lcc_pkg::SET_FULL, lcc_pkg::SET_TENTH}))
        else $error("charging continues with temperature out of range");
endmodule : lcc_charger_sva

bind lcc_charger lcc_charger_sva i_lcc_charger_sva (
    .clk_sys(clk_sys), .resetn(resetn), .enable_n(enable_n), .sense(sense),
    .power_good_n_oe(power_good_n_oe), .charging_n_oe(charging_n_oe),
    .fault_n_oe(fault_n_oe), .setpoint(setpoint));
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the charge controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TK = 10; // cycles per tick, shortened for simulation
    localparam int PQ = 3;
    localparam int CH = 5;
    localparam int TO = 3;
    logic                clk_sys = 1'b0, resetn = 1'b0, enable_n = 1'b1, taper = 1'b0;
    int                  supply_mv = 0, bat_mv = 2500, thm_ohm = 10000, seed = 32'h7f98;
    int                  n_mismatch = 0, tests_run = 0;
    lcc_pkg::lcc_sense_t sense;
    logic                pg_oe, chg_oe, flt_oe, irq, pg_pin, chg_pin, flt_pin;
    logic [1:0]          setpoint, bresp, rresp;
    logic [5:0]          awaddr = 6'h00, araddr = 6'h00;
    logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0]         wdata = 32'h0, rdata;
    logic                awready, wready, bvalid, arready, rvalid;

    always #5 clk_sys = ~clk_sys;

    lcc_charger #(.TICK_CYCLES(TK), .PREQUAL_LIM(PQ), .CHARGE_LIM(CH), .TOPOFF_LIM(TO)) i_lcc_charger (
        .clk_sys(clk_sys), .resetn(resetn), .enable_n(enable_n), .sense(sense),
        .power_good_n_oe(pg_oe), .charging_n_oe(chg_oe), .fault_n_oe(flt_oe),
        .setpoint(setpoint), .irq(irq), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
    lcc_cell_model i_lcc_cell_model (
        .supply_mv(supply_mv), .bat_mv(bat_mv), .thm_ohm(thm_ohm), .taper(taper),
        .power_good_n_oe(pg_oe), .charging_n_oe(chg_oe), .fault_n_oe(flt_oe),
        .sense(sense), .power_good_n(pg_pin), .charging_n(chg_pin), .fault_n(flt_pin));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // bounded wait until setpoint (w=0) or fault flag (w=1) shows v
    task automatic wait_on(input int w, input logic [1:0] v, input int lim, output int n);
        n = 0;
        while ((w == 0 ? setpoint : {1'b0, flt_oe}) !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
    endtask : wait_on
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && k < 50);
        bready <= 1'b0;
        chk("bvalid", 1'b1, bvalid);
        chk("bresp", lcc_pkg::RESP_OKAY, bresp);
    endtask : axi_wr
    // read and compare the masked word and the response code
    task automatic axi_rd(input logic [5:0] a, input logic [31:0] e, m, input logic [1:0] er);
        int k;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && k < 50);
        rready <= 1'b0;
        chk("rvalid", 1'b1, rvalid);
        chk("rresp", er, rresp);
        chk("rdata", e, rdata & m);
    endtask : axi_rd
    function automatic logic pg_exp(input int mv);
        return mv >= 4150 && mv <= 7000;
    endfunction : pg_exp
    function automatic logic thm_ok(input int r);
        return r < 315 || (r >= 3940 && r <= 28300);
    endfunction : thm_ok
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end

    initial begin : main
        int n, mv;
        static int tv[4] = '{100, 1000, 10000, 40000};
        static int cv[5] = '{4150, 7000, 7001, 8000, 3000};
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        chk("setpoint", lcc_pkg::SET_OFF, setpoint);
        axi_rd(lcc_pkg::REG_STATUS, 32'h1, 32'h7f, lcc_pkg::RESP_OKAY);
        axi_rd(lcc_pkg::REG_CTRL, 32'h8, 32'hff, lcc_pkg::RESP_OKAY);
        axi_rd(lcc_pkg::REG_IRQ_MSK, 32'h0, 32'hf, lcc_pkg::RESP_OKAY);
        axi_rd(6'h3c, 32'h0, 32'hffff_ffff, lcc_pkg::RESP_SLVERR);
        // supply sweep: corners first, then random levels
        for (int i = 0; i < 16; i++) begin
            mv = i < 5 ? cv[i] : 3000 + int'($unsigned($random(seed)) % 6000);
            supply_mv <= mv;
            repeat (10) @(posedge clk_sys);
            chk("pgood_oe", pg_exp(mv), pg_oe);
            chk("pgood_pin", !pg_exp(mv), pg_pin);
        end
        // precharge timeout at two timer scales, fault latch and interrupt
        supply_mv <= 5000;
        for (int s = 1; s <= 2; s++) begin
            axi_wr(lcc_pkg::REG_CTRL, 32'(8 * s));
            axi_wr(lcc_pkg::REG_IRQ_MSK, 32'h1 << lcc_pkg::EV_FAULT);
            bat_mv <= 2500;
            enable_n <= 1'b0;
            wait_on(0, lcc_pkg::SET_TENTH, 20, n);
            chk("setpoint", lcc_pkg::SET_TENTH, setpoint);
            chk("charging_pin", 1'b1, chg_pin);
            wait_on(1, 2'h1, 40 * s, n);
            chk("fault_pin", 1'b0, flt_pin);
            chk("prequal_span", 1'b1, n >= (PQ * s - 1) * TK && n <= (PQ * s + 1) * TK);
            repeat (3) @(posedge clk_sys);
            chk("irq", 1'b1, irq);
            axi_wr(lcc_pkg::REG_IRQ_ST, 32'hf);
            repeat (3) @(posedge clk_sys);
            chk("irq", 1'b0, irq);
            bat_mv <= 3500;
            repeat (20) @(posedge clk_sys);
            chk("fault_oe", 1'b1, flt_oe);
            enable_n <= 1'b1;
            wait_on(1, 2'h0, 20, n);
            chk("fault_oe", 1'b0, flt_oe);
        end
        // fast charge, thermistor windows, frozen timer, charge timeout
        axi_wr(lcc_pkg::REG_CTRL, 32'h8);
        enable_n <= 1'b0;
        wait_on(0, lcc_pkg::SET_FULL, 30, n);
        chk("setpoint", lcc_pkg::SET_FULL, setpoint);
        chk("charging_pin", 1'b0, chg_pin);
        for (int i = 0; i < 4; i++) begin
            thm_ohm <= tv[i];
            repeat (10) @(posedge clk_sys);
            chk("setpoint", thm_ok(tv[i]) ? lcc_pkg::SET_FULL : lcc_pkg::SET_OFF, setpoint);
            chk("charging_oe", 1'b1, chg_oe);
        end
        repeat (2 * CH * TK) @(posedge clk_sys);
        thm_ohm <= 10000;
        wait_on(0, lcc_pkg::SET_FULL, 20, n);
        @(posedge clk_sys);
        chk("fault_oe", 1'b0, flt_oe);
        wait_on(1, 2'h1, (CH + 1) * TK, n);
        chk("fault_oe", 1'b1, flt_oe);
        // top-off, done and recharge
        enable_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        enable_n <= 1'b0;
        wait_on(0, lcc_pkg::SET_FULL, 30, n);
        taper <= 1'b1;
        bat_mv <= 4150;
        wait_on(0, lcc_pkg::SET_TOPOFF, 20, n);
        chk("setpoint", lcc_pkg::SET_TOPOFF, setpoint);
        chk("charging_oe", 1'b0, chg_oe);
        wait_on(0, lcc_pkg::SET_OFF, (TO + 1) * TK, n);
        chk("topoff_span", 1'b1, setpoint === lcc_pkg::SET_OFF && n >= (TO - 1) * TK);
        axi_rd(lcc_pkg::REG_STATUS, {25'h0, lcc_pkg::ST_DONE}, 32'h7f, lcc_pkg::RESP_OKAY);
        taper <= 1'b0;
        bat_mv <= 4000;
        wait_on(0, lcc_pkg::SET_FULL, 20, n);
        chk("setpoint", lcc_pkg::SET_FULL, setpoint);
        supply_mv <= 8000;
        wait_on(0, lcc_pkg::SET_OFF, 20, n);
        chk("setpoint", lcc_pkg::SET_OFF, setpoint);
        axi_rd(lcc_pkg::REG_STATUS, 32'h1, 32'h17f, lcc_pkg::RESP_OKAY);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
